// ===== core/smh_hub.sv
// Ten-port merger hub: mode control, configuration, routing and indicators
// Behaviour
// - Activity indicator flashes while the join request is pending.
// - After enumeration the activity indicator is steadily on.
// - Managed operation entered only by controller command, no local setting.
// - Managed indicator lit while the network is computer managed.
// - Ten network ports, numbered one through ten.
// - Port routing depends only on mode and, when fixed, configuration.
// - In full-merge mode all ten ports behave identically.
// - Exactly one of three configurations always selected, indicator lit.
// - Each button press advances selection A, B, C cyclically.
// - Selected configuration indicator stays lit in any network mode.
// - Switching to fixed routing applies the selected configuration at once.
// - Front configuration indicator lights only in fixed-routing mode.
// - Every port receives and transmits continuously and simultaneously.
// - Merger and hub have no own settings; mode and configuration rule.
// - Each hub holds its own configuration selection.
// - Full-merge combines audio and side data of all ports to every port.
// - Configuration A merges all ports and sends to all ten.
// - Configuration B: ports 1-9 merged to port 10, port 10 to 1-9.
// - Configuration C: ports 1-8 merged out on ports 8, 9 and 10.
// - Configuration C: ports 9,10 audio to 1-7; side data merged from all.
//
// Design decisions made here: strobed register access and the register addresses.
module smh_hub
  import smh_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int BLINK_HALF = BLINK_TICKS
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Port receive streams (pins)
  input wire logic [NUM_PORTS-1:0][AUDIO_W-1:0] rx_audio,
  input wire logic [NUM_PORTS-1:0][SIDE_W-1:0] rx_side,
  input wire logic [NUM_PORTS-1:0] rx_valid,
  // Port transmit streams
  output logic [NUM_PORTS-1:0][AUDIO_W-1:0] tx_audio,
  output logic [NUM_PORTS-1:0][SIDE_W-1:0] tx_side,
  output logic [NUM_PORTS-1:0] tx_valid,
  // Network controller commands (from network logic on clk_sys)
  input wire logic cmd_valid,
  input wire smh_pkg::smh_cmd_t cmd_code,
  output logic join_req,
  // Configuration button (pin)
  input wire logic cfg_button,
  // Indicators
  output logic led_join,
  output logic led_managed,
  output logic led_mode_full,
  output logic led_mode_fixed,
  output logic [2:0] led_cfg_rear,
  output logic [2:0] led_cfg_front,
  output logic [NUM_PORTS-1:0] led_port_act,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata
);
  import smh_pkg::*;

  logic [NUM_PORTS-1:0][AUDIO_W-1:0] aud_s1_r;
  logic [NUM_PORTS-1:0][AUDIO_W-1:0] aud_s2_r;
  logic [NUM_PORTS-1:0][SIDE_W-1:0] side_s1_r;
  logic [NUM_PORTS-1:0][SIDE_W-1:0] side_s2_r;
  logic [NUM_PORTS-1:0] val_s1_r;
  logic [NUM_PORTS-1:0] val_s2_r;
  logic [17:0] tick_cnt_r;
  logic tick_r;
  logic [11:0] blink_cnt_r;
  logic blink_r;
  logic press;
  smh_mode_t mode_r;
  smh_cfg_t cfg_r;
  smh_join_t join_r;
  logic managed_r;
  logic rejoin_r;
  logic [NUM_SRC-1:0][AUDIO_W-1:0] src_audio;
  logic [SIDE_W-1:0] side_all;

  // Port routing source, from network mode and selected configuration only
  function automatic smh_src_t route_src(smh_mode_t mode, smh_cfg_t cfg, int port);
    smh_src_t s;
    s = SMH_SRC_ALL;
    if (mode == SMH_MODE_FIXED)
    begin
      unique case (cfg)
        SMH_CFG_A: s = SMH_SRC_ALL;
        SMH_CFG_B: s = (port == NUM_PORTS - 1) ? SMH_SRC_1_9 : SMH_SRC_10;
        SMH_CFG_C: s = (port >= 7) ? SMH_SRC_1_8 : SMH_SRC_9_10;
        default: s = SMH_SRC_ALL;
      endcase
    end
    return s;
  endfunction

  // One-hot indicator for a configuration
  function automatic logic [2:0] cfg_onehot(smh_cfg_t cfg);
    logic [2:0] v;
    v = 3'h0;
    unique case (cfg)
      SMH_CFG_A: v = 3'h1;
      SMH_CFG_B: v = 3'h2;
      SMH_CFG_C: v = 3'h4;
      default: v = 3'h1;
    endcase
    return v;
  endfunction

  // Receive pins cross into clk_sys through two flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aud_s1_r <= '0;
      aud_s2_r <= '0;
      side_s1_r <= '0;
      side_s2_r <= '0;
      val_s1_r <= '0;
      val_s2_r <= '0;
    end
    else
    begin
      aud_s1_r <= rx_audio;
      aud_s2_r <= aud_s1_r;
      side_s1_r <= rx_side;
      side_s2_r <= side_s1_r;
      val_s1_r <= rx_valid;
      val_s2_r <= val_s1_r;
    end
  end

  // Millisecond time base
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 18'h0_0000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      if (tick_cnt_r == 18'(TICK_DIV - 1))
      begin
        tick_cnt_r <= 18'h0_0000;
        tick_r <= 1'b1;
      end
      else
        tick_cnt_r <= tick_cnt_r + 18'h0_0001;
    end
  end

  // Flash rate for the pending join
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      blink_cnt_r <= 12'h000;
      blink_r <= 1'b1;
    end
    else if (tick_r)
    begin
      if (blink_cnt_r == 12'(BLINK_HALF - 1))
      begin
        blink_cnt_r <= 12'h000;
        blink_r <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 12'h001;
    end
  end

  smh_debounce u_debounce (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick_r),
    .button_pin(cfg_button),
    .press(press)
  );

  // Selection lives only in this hub; reset picks A so one is always chosen
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfg_r <= SMH_CFG_A;
    else if (press)
    begin
      unique case (cfg_r)
        SMH_CFG_A: cfg_r <= SMH_CFG_B;
        SMH_CFG_B: cfg_r <= SMH_CFG_C;
        SMH_CFG_C: cfg_r <= SMH_CFG_A;
        default: cfg_r <= SMH_CFG_A;
      endcase
    end
  end

  // Mode follows the controller only, never a local input
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_r <= SMH_MODE_FULL;
    else if (cmd_valid && cmd_code == SMH_CMD_MODE_FULL)
      mode_r <= SMH_MODE_FULL;
    else if (cmd_valid && cmd_code == SMH_CMD_MODE_FIXED)
      mode_r <= SMH_MODE_FIXED;
  end

  // Managed operation has no software or panel path in
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      managed_r <= 1'b0;
    else if (cmd_valid && cmd_code == SMH_CMD_MANAGED_ON)
      managed_r <= 1'b1;
    else if (cmd_valid && cmd_code == SMH_CMD_MANAGED_OFF)
      managed_r <= 1'b0;
  end

  // Join state: pending until enumerated; release or software retry re-arms it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      join_r <= SMH_JOIN_PEND;
    else
    begin
      unique case (join_r)
        SMH_JOIN_PEND:
          if (cmd_valid && cmd_code == SMH_CMD_ENUM)
            join_r <= SMH_JOIN_DONE;
        SMH_JOIN_DONE:
          if ((cmd_valid && cmd_code == SMH_CMD_RELEASE) || rejoin_r)
            join_r <= SMH_JOIN_PEND;
      endcase
    end
  end

  // Merger sources, one per port mask
  generate
    for (genvar s = 0; s < NUM_SRC; s++)
    begin : g_src
      smh_merge #(.W(AUDIO_W)) u_merge (
        .mask(SRC_MASKS[s]),
        .valid(val_s2_r),
        .data_in(aud_s2_r),
        .data_out(src_audio[s])
      );
    end
  endgenerate

  // Side data channel is merged from every port in every mode
  smh_merge #(.W(SIDE_W)) u_side (
    .mask(MASK_ALL),
    .valid(val_s2_r),
    .data_in(side_s2_r),
    .data_out(side_all)
  );

  // Hub section: every port transmits every cycle, routing re-evaluated each cycle
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_tx
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          tx_audio[p] <= '0;
          tx_side[p] <= '0;
          tx_valid[p] <= 1'b0;
        end
        else
        begin
          tx_audio[p] <= src_audio[route_src(mode_r, cfg_r, p)];
          tx_side[p] <= side_all;
          tx_valid[p] <= 1'b1;
        end
      end
    end
  endgenerate

  // Indicators
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      join_req <= 1'b0;
      led_join <= 1'b0;
      led_managed <= 1'b0;
      led_mode_full <= 1'b0;
      led_mode_fixed <= 1'b0;
      led_cfg_rear <= 3'h0;
      led_cfg_front <= 3'h0;
      led_port_act <= '0;
    end
    else
    begin
      join_req <= (join_r == SMH_JOIN_PEND);
      led_join <= (join_r == SMH_JOIN_DONE) ? 1'b1 : blink_r;
      led_managed <= managed_r;
      led_mode_full <= (mode_r == SMH_MODE_FULL);
      led_mode_fixed <= (mode_r == SMH_MODE_FIXED);
      led_cfg_rear <= cfg_onehot(cfg_r);
      led_cfg_front <= (mode_r == SMH_MODE_FIXED) ? cfg_onehot(cfg_r) : 3'h0;
      led_port_act <= val_s2_r;
    end
  end

  // Software retry of the join request; a one-cycle pulse
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rejoin_r <= 1'b0;
    else
      rejoin_r <= reg_we && reg_addr == REG_CTRL && reg_wdata[CTRL_REJOIN];
  end

  // Read data stands one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= REG_ZERO;
    else
    begin
      reg_rdata <= REG_ZERO;
      if (reg_re)
      begin
        if (reg_addr == REG_STATUS)
        begin
          reg_rdata[ST_MODE_FIXED] <= (mode_r == SMH_MODE_FIXED);
          reg_rdata[ST_MANAGED] <= managed_r;
          reg_rdata[ST_JOINED] <= (join_r == SMH_JOIN_DONE);
          reg_rdata[ST_CFG_LSB +: 2] <= cfg_r;
        end
        else if (reg_addr == REG_ACTIVITY)
          reg_rdata[NUM_PORTS-1:0] <= val_s2_r;
      end
    end
  end
endmodule

// ===== core/smh_pkg.sv
// Shared constants and types for the ten-port stream merger hub
package smh_pkg;
  localparam int NUM_PORTS = 10;
  localparam int AUDIO_W = 16;
  localparam int SIDE_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CMD_W = 3;

  // Clock rate and the slow time base
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEBOUNCE_MS = 10;
  localparam int BLINK_HALF_MS = 250;
  localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
  localparam int BLINK_TICKS = BLINK_HALF_MS * 1000 / TICK_US;

  // Port masks for the merger sources (bit 0 is port one)
  localparam int NUM_SRC = 5;
  localparam logic [NUM_PORTS-1:0] MASK_ALL = 10'h3ff;
  localparam logic [NUM_PORTS-1:0] MASK_1_9 = 10'h1ff;
  localparam logic [NUM_PORTS-1:0] MASK_1_8 = 10'h0ff;
  localparam logic [NUM_PORTS-1:0] MASK_9_10 = 10'h300;
  localparam logic [NUM_PORTS-1:0] MASK_10 = 10'h200;
  localparam logic [NUM_SRC-1:0][NUM_PORTS-1:0] SRC_MASKS =
    {MASK_10, MASK_9_10, MASK_1_8, MASK_1_9, MASK_ALL};

  // Register offsets and fields
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ACTIVITY = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;
  localparam int ST_MODE_FIXED = 0;
  localparam int ST_MANAGED = 1;
  localparam int ST_JOINED = 2;
  localparam int ST_CFG_LSB = 4;
  localparam int CTRL_REJOIN = 0;
  localparam logic [DATA_W-1:0] REG_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    SMH_CMD_ENUM,
    SMH_CMD_MODE_FULL,
    SMH_CMD_MODE_FIXED,
    SMH_CMD_MANAGED_ON,
    SMH_CMD_MANAGED_OFF,
    SMH_CMD_RELEASE
  } smh_cmd_t;

  typedef enum logic {SMH_MODE_FULL, SMH_MODE_FIXED} smh_mode_t;
  typedef enum logic [1:0] {SMH_CFG_A, SMH_CFG_B, SMH_CFG_C} smh_cfg_t;
  typedef enum logic [2:0] {
    SMH_SRC_ALL,
    SMH_SRC_1_9,
    SMH_SRC_1_8,
    SMH_SRC_9_10,
    SMH_SRC_10
  } smh_src_t;
  typedef enum logic {SMH_JOIN_PEND, SMH_JOIN_DONE} smh_join_t;
endpackage

// ===== core/smh_debounce.sv
// Button synchroniser and debouncer giving one pulse per press
module smh_debounce
  import smh_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Time base and button
  input wire logic tick,
  input wire logic button_pin,
  // Press event
  output logic press
);
  logic sync1_r;
  logic sync2_r;
  logic stable_r;
  logic [15:0] cnt_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= button_pin;
      sync2_r <= sync1_r;
    end
  end

  // A level must hold for the full window before it is accepted
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stable_r <= 1'b0;
      cnt_r <= 16'h0000;
      press <= 1'b0;
    end
    else
    begin
      press <= 1'b0;
      if (sync2_r == stable_r)
        cnt_r <= 16'h0000;
      else if (tick)
      begin
        if (cnt_r == 16'(DEBOUNCE_TICKS - 1))
        begin
          stable_r <= sync2_r;
          cnt_r <= 16'h0000;
          press <= sync2_r;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule

// ===== core/smh_merge.sv
// Combinational merge of the port streams selected by a mask
module smh_merge
  import smh_pkg::*;
#(
  parameter int W = AUDIO_W
)
(
  // Selection
  input wire logic [NUM_PORTS-1:0] mask,
  input wire logic [NUM_PORTS-1:0] valid,
  // Streams
  input wire logic [NUM_PORTS-1:0][W-1:0] data_in,
  output logic [W-1:0] data_out
);
  // Slots on the network are disjoint, so an OR of live ports merges them
  always_comb
  begin
    data_out = '0;
    for (int p = 0; p < NUM_PORTS; p++)
      if (mask[p] && valid[p])
        data_out = data_out | data_in[p];
  end
endmodule

// ===== testbench/smh_hub_chk.sv
// Assertion checker for the stream merger hub, bound to its top module
module smh_hub_chk
  import smh_pkg::*;
#(
  parameter int TICK_DIV = 4,
  parameter int BLINK_HALF = 2
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Streams
  input wire logic [NUM_PORTS-1:0][SIDE_W-1:0] rx_side,
  input wire logic [NUM_PORTS-1:0] rx_valid,
  input wire logic [NUM_PORTS-1:0][AUDIO_W-1:0] tx_audio,
  input wire logic [NUM_PORTS-1:0][SIDE_W-1:0] tx_side,
  input wire logic [NUM_PORTS-1:0] tx_valid,
  // Commands and indicators
  input wire logic cmd_valid,
  input wire smh_pkg::smh_cmd_t cmd_code,
  input wire logic join_req,
  input wire logic led_join,
  input wire logic led_managed,
  input wire logic led_mode_full,
  input wire logic led_mode_fixed,
  input wire logic [2:0] led_cfg_rear,
  input wire logic [2:0] led_cfg_front
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_r;
  logic [7:0] still_r;
  logic join_led_r;
  logic [SIDE_W-1:0] side_or;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Edges since reset, so the pipeline has flushed before streams are judged
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      join_led_r <= 1'b0;
    else
      join_led_r <= led_join;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      still_r <= 8'h00;
    else if (!join_req || led_join != join_led_r)
      still_r <= 8'h00;
    else if (still_r != 8'hff)
      still_r <= still_r + 8'h01;
  end
  always_comb
  begin
    side_or = '0;
    for (int p = 0; p < NUM_PORTS; p++)
      side_or = side_or | (rx_valid[p] ? rx_side[p] : '0);
  end
  a_blink_runs: assert property (still_r <= TICK_DIV * BLINK_HALF + 4)
    else $error("activity indicator stopped flashing while joining");
  a_join_steady: assert property (up_r > 3'h1 && !join_req && !$past(join_req) |-> led_join)
    else $error("activity indicator not steady after join");
  a_managed_on: assert property (cmd_valid && cmd_code == SMH_CMD_MANAGED_ON |-> ##2 led_managed)
    else $error("managed indicator not lit after command");
  a_managed_src: assert property (up_r > 3'h2 && $changed(led_managed) |-> $past(cmd_valid, 2))
    else $error("managed indicator changed without a command");
  a_rear_onehot: assert property (up_r != 3'h0 |-> $onehot(led_cfg_rear))
    else $error("selection indicator not exactly one");
  a_front_only: assert property (led_cfg_front != 3'h0 |-> led_mode_fixed)
    else $error("front selection lit outside fixed mode");
  a_front_match: assert property (led_mode_fixed |-> led_cfg_front == led_cfg_rear)
    else $error("front selection differs from rear");
  a_fixed_cmd: assert property (cmd_valid && cmd_code == SMH_CMD_MODE_FIXED |->
    ##2 led_mode_fixed && led_cfg_front == led_cfg_rear)
    else $error("fixed mode not applied in time");
  a_full_cmd: assert property (cmd_valid && cmd_code == SMH_CMD_MODE_FULL |->
    ##2 led_mode_full && led_cfg_front == 3'h0)
    else $error("full mode not applied in time");
  a_mode_one: assert property (up_r != 3'h0 |-> led_mode_full != led_mode_fixed)
    else $error("mode indicators not exclusive");
  a_tx_valid: assert property (up_r != 3'h0 |-> tx_valid == '1)
    else $error("a port stopped transmitting");
  a_side_merge: assert property (up_r == 3'h7 |-> tx_side == {NUM_PORTS{$past(side_or, 3)}})
    else $error("side data not merged to every port");
  a_full_same: assert property (up_r == 3'h7 && (led_mode_full || led_cfg_front == 3'h1) |->
    tx_audio == {NUM_PORTS{tx_audio[0]}})
    else $error("ports differ while merging all");
  cover property (cmd_valid && cmd_code == SMH_CMD_MODE_FIXED);
  cover property ($rose(led_cfg_rear[2]));
  cover property ($fell(join_req));
endmodule
bind smh_hub smh_hub_chk #(.TICK_DIV(TICK_DIV), .BLINK_HALF(BLINK_HALF)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .rx_side(rx_side), .rx_valid(rx_valid),
  .tx_audio(tx_audio), .tx_side(tx_side), .tx_valid(tx_valid), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .join_req(join_req), .led_join(led_join), .led_managed(led_managed),
  .led_mode_full(led_mode_full), .led_mode_fixed(led_mode_fixed),
  .led_cfg_rear(led_cfg_rear), .led_cfg_front(led_cfg_front));

// ===== testbench/smh_peer_model.sv
// Far-side peers: one stream source on each hub port
module smh_peer_model
  import smh_pkg::*;
(
  // Clock and attached peers (bit 0 is port one)
  input wire logic clk_sys,
  input wire logic [NUM_PORTS-1:0] attach,
  // Streams into the hub
  output logic [NUM_PORTS-1:0][AUDIO_W-1:0] rx_audio,
  output logic [NUM_PORTS-1:0][SIDE_W-1:0] rx_side,
  output logic [NUM_PORTS-1:0] rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r;
  initial
  begin
    flip_r = 1'b0;
    rx_audio = '0;
    rx_side = '0;
    rx_valid = '0;
  end
  // Detached ports show a pattern that changes every cycle, never a held word
  always @(posedge clk_sys)
  begin
    flip_r <= !flip_r;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      rx_valid[p] <= attach[p];
      rx_audio[p] <= attach[p] ? 16'h0001 << p : {AUDIO_W{flip_r}};
      rx_side[p] <= attach[p] ? 8'h01 << (p % 8) : {SIDE_W{!flip_r}};
    end
  end
endmodule

// ===== testbench/smh_hub_bench.sv
// Self-checking bench for the ten-port stream merger hub
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module smh_hub_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import smh_pkg::*;
  typedef struct packed {logic fx; logic [1:0] cfg; logic [9:0] att;} smh_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [9:0] attach = 10'h3ff;
  logic [9:0][15:0] rx_audio, tx_audio;
  logic [9:0][7:0] rx_side, tx_side;
  logic [9:0] rx_valid, tx_valid, led_port_act;
  logic cmd_valid = 1'b0;
  smh_cmd_t cmd_code = SMH_CMD_ENUM;
  logic cfg_button = 1'b0;
  logic join_req, led_join, led_managed, led_mode_full, led_mode_fixed;
  logic [2:0] led_cfg_rear, led_cfg_front, prev;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  int failures = 0;
  int n_compared = 0;
  int tg;
  smh_row_t rows [7] = '{'{1'b0, 2'd0, 10'h3ff}, '{1'b0, 2'd1, 10'h3f7}, '{1'b1, 2'd1, 10'h3ff},
    '{1'b1, 2'd2, 10'h2ef}, '{1'b1, 2'd0, 10'h1ff}, '{1'b1, 2'd2, 10'h37f},
    '{1'b0, 2'd2, 10'h3ff}};
  always #2.5 clk_sys = !clk_sys;
  smh_peer_model i_peers (.clk_sys(clk_sys), .attach(attach), .rx_audio(rx_audio),
    .rx_side(rx_side), .rx_valid(rx_valid));
  // Short time base so debounce and blink fit a brief run
  smh_hub #(.TICK_DIV(4), .BLINK_HALF(2)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .rx_audio(rx_audio), .rx_side(rx_side), .rx_valid(rx_valid), .tx_audio(tx_audio),
    .tx_side(tx_side), .tx_valid(tx_valid), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .join_req(join_req), .cfg_button(cfg_button), .led_join(led_join),
    .led_managed(led_managed), .led_mode_full(led_mode_full), .led_mode_fixed(led_mode_fixed),
    .led_cfg_rear(led_cfg_rear), .led_cfg_front(led_cfg_front), .led_port_act(led_port_act),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cmd(smh_cmd_t c);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cyc(6);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge clk_sys);
  endtask
  // A bounce shorter than the debounce window must give no step
  task automatic press(int hold);
    cfg_button <= 1'b1;
    cyc(hold);
    cfg_button <= 1'b0;
    cyc(60);
  endtask
  function automatic logic [2:0] onehot(logic [1:0] c);
    return 3'h1 << c;
  endfunction
  function automatic logic [9:0] route(logic fx, logic [1:0] c, int p);
    if (!fx || c == 2'd0)
      return 10'h3ff;
    if (c == 2'd1)
      return (p == 9) ? 10'h1ff : 10'h200;
    return (p >= 7) ? 10'h0ff : 10'h300;
  endfunction
  task automatic check_row(smh_row_t w);
    logic [7:0] s;
    s = 8'h00;
    for (int p = 0; p < 10; p++)
      s = s | (w.att[p] ? 8'h01 << (p % 8) : 8'h00);
    #1;
    for (int p = 0; p < 10; p++)
    begin
      `CHK("tx_audio", {6'h00, route(w.fx, w.cfg, p) & w.att}, tx_audio[p])
      `CHK("tx_side", s, tx_side[p])
    end
    `CHK("led_cfg_front", w.fx ? onehot(w.cfg) : 3'h0, led_cfg_front)
    `CHK("led_mode_fixed", w.fx, led_mode_fixed)
    `CHK("led_port_act", w.att, led_port_act)
    @(posedge clk_sys);
    rd(REG_STATUS, {26'h0, w.cfg, 3'h0, w.fx});
    rd(REG_ACTIVITY, {22'h0, w.att});
  endtask
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    cyc(100000);
    failures++;
    end_of_test();
  end
  initial
  begin
    cyc(5);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("tx_valid", 10'h3ff, tx_valid)
    `CHK("led_cfg_rear", 3'h1, led_cfg_rear)
    `CHK("led_mode_full", 1'b1, led_mode_full)
    tg = 0;
    for (int i = 0; i < 40; i++)
    begin
      prev[0] = led_join;
      @(posedge clk_sys);
      #1;
      tg += int'(led_join != prev[0]);
    end
    `CHK("led_join toggles", 1'b1, tg >= 3)
    @(posedge clk_sys);
    for (int r = 0; r < 7; r++)
    begin
      attach <= rows[r].att;
      for (int k = 0; k < 3 && led_cfg_rear !== onehot(rows[r].cfg); k++)
      begin
        prev = led_cfg_rear;
        press(60);
        `CHK("led_cfg_rear step", {prev[1:0], prev[2]}, led_cfg_rear)
      end
      cmd(rows[r].fx ? SMH_CMD_MODE_FIXED : SMH_CMD_MODE_FULL);
      check_row(rows[r]);
    end
    press(6);
    `CHK("led_cfg_rear bounce", 3'h4, led_cfg_rear)
    cmd(SMH_CMD_ENUM);
    tg = 0;
    for (int i = 0; i < 30; i++)
    begin
      @(posedge clk_sys);
      tg += int'(led_join !== 1'b1);
    end
    `CHK("led_join steady", 0, tg)
    `CHK("join_req", 1'b0, join_req)
    cmd(SMH_CMD_MANAGED_ON);
    `CHK("led_managed", 1'b1, led_managed)
    wr(REG_STATUS, 32'hffff_fffd);
    wr(REG_CTRL, 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0026);
    rd(4'hc, 32'h0000_0000);
    cmd(SMH_CMD_MANAGED_OFF);
    `CHK("led_managed", 1'b0, led_managed)
    cmd(SMH_CMD_RELEASE);
    `CHK("join_req", 1'b1, join_req)
    cmd(SMH_CMD_ENUM);
    `CHK("led_join", 1'b1, led_join)
    wr(REG_CTRL, 32'h0000_0001);
    cyc(4);
    `CHK("join_req", 1'b1, join_req)
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    `CHK("led_cfg_rear", 3'h1, led_cfg_rear)
    end_of_test();
  end
endmodule
